// >>> rtl/osc_defs.svh
// Constants for the output setpoint configuration bank
`ifndef OSC_DEFS_SVH
`define OSC_DEFS_SVH

// ****************************************
// Command codes and word indices
// ****************************************
`define OSC_CMD_TRIM 8'h22
`define OSC_CMD_CAL 8'h23
`define OSC_CMD_CEIL 8'h24
`define OSC_CMD_MHIGH 8'h25
`define OSC_CMD_MLOW 8'h26
`define OSC_CMD_SLEW 8'h27
`define OSC_CMD_DROOP 8'h28
`define OSC_CMD_FREQ 8'h33
`define OSC_CMD_PLACE 8'h37
`define OSC_CMD_GAIN 8'h38
`define OSC_CMD_IOFS 8'h39
`define OSC_CMD_OVT 8'h40
`define OSC_IDX_TRIM 4'h0
`define OSC_IDX_CAL 4'h1
`define OSC_IDX_CEIL 4'h2
`define OSC_IDX_MHIGH 4'h3
`define OSC_IDX_MLOW 4'h4
`define OSC_IDX_SLEW 4'h5
`define OSC_IDX_DROOP 4'h6
`define OSC_IDX_FREQ 4'h7
`define OSC_IDX_PLACE 4'h8
`define OSC_IDX_GAIN 4'h9
`define OSC_IDX_IOFS 4'ha
`define OSC_IDX_OVT 4'hb
`define OSC_NUM_WORDS 12

// ****************************************
// Reset values
// ****************************************
`define OSC_WORD_RST 16'h0000
`define OSC_CEIL_RST 16'hffff

// ****************************************
// Field positions
// ****************************************
`define OSC_FMT_MSB 7
`define OSC_FMT_LSB 5
`define OSC_FMT_LINEAR 3'h0
`define OSC_EXP_MSB 4
`define OSC_EXP_LSB 0
`define OSC_LIN_MANT_MSB 10
`define OSC_LIN_EXP_MSB 15
`define OSC_LIN_EXP_LSB 11
`define OSC_RAILS_MSB 7
`define OSC_RAILS_LSB 4
`define OSC_POS_MSB 3
`define OSC_POS_LSB 0

// ****************************************
// Margin select codes
// ****************************************
`define OSC_MARGIN_LOW 2'h1
`define OSC_MARGIN_HIGH 2'h2

// ****************************************
// Scaling and limits
// ****************************************
`define OSC_TRIM_LIMIT_MV 32'sd150
`define OSC_MV_PER_V 32'sd1000
`define OSC_CEIL_PCT 32'd115
`define OSC_PCT_FULL 32'd100
`define OSC_RAILS_ZERO_AS 5'h10
`define OSC_FULL_TURN_DEG 32'd360
`define OSC_FREQ_MIN_KHZ 32'sd571
`define OSC_FREQ_MAX_KHZ 32'sd800

// ****************************************
// Timing
// ****************************************
`define OSC_CLK_PERIOD_NS 50
`define OSC_RAMP_TICK_NS 1000000

`endif

// >>> rtl/osc_pkg.sv
// Types shared by the output setpoint configuration bank
package osc_pkg;
   typedef logic [15:0] osc_word_t;
   typedef enum logic [1:0] {OSC_RAMP_IDLE, OSC_RAMP_UP, OSC_RAMP_DOWN} osc_ramp_t;
endpackage

// >>> rtl/osc_bank.sv
// Output setpoint configuration word bank with setpoint, ramp, droop and sense datapath
`timescale 1ns/10ps
`include "osc_defs.svh"
module osc_bank
   import osc_pkg::*;
#(
   parameter int RAMP_TICK_CYCLES = `OSC_RAMP_TICK_NS / `OSC_CLK_PERIOD_NS,
   parameter int NUM_WORDS = `OSC_NUM_WORDS
)
(
   // Clock, reset, enable
   input wire logic clk,
   input wire logic reset,
   input wire logic ce,
   // Word access port
   input wire logic cmd_valid,
   input wire logic cmd_write,
   input wire logic [7:0] cmd_code,
   input wire logic [15:0] cmd_wdata,
   output logic rsp_valid,
   output logic rsp_nack,
   output logic [15:0] rsp_rdata,
   // Operating inputs
   input wire logic [15:0] nominal_setpoint,
   input wire logic [1:0] margin_sel,
   input wire logic running,
   input wire logic [7:0] vout_mode,
   input wire logic [15:0] setpoint_strap_pin,
   input wire logic [15:0] load_current,
   input wire logic [15:0] sense_mv,
   input wire logic [15:0] measured_vout,
   // Derived outputs
   output logic [15:0] setpoint_target,
   output logic [15:0] vout_setpoint,
   output logic ramp_busy,
   output logic [15:0] switch_khz,
   output logic freq_in_range,
   output logic [4:0] rail_count,
   output logic [3:0] rail_position,
   output logic [8:0] phase_deg,
   output logic [15:0] iout_reading,
   output logic ov_fault
);

   // ****************************************
   // Helper functions
   // ****************************************
   function automatic logic [4:0] word_lookup(input logic [7:0] code);
      case (code)
         `OSC_CMD_TRIM: word_lookup = {1'b1, `OSC_IDX_TRIM};
         `OSC_CMD_CAL: word_lookup = {1'b1, `OSC_IDX_CAL};
         `OSC_CMD_CEIL: word_lookup = {1'b1, `OSC_IDX_CEIL};
         `OSC_CMD_MHIGH: word_lookup = {1'b1, `OSC_IDX_MHIGH};
         `OSC_CMD_MLOW: word_lookup = {1'b1, `OSC_IDX_MLOW};
         `OSC_CMD_SLEW: word_lookup = {1'b1, `OSC_IDX_SLEW};
         `OSC_CMD_DROOP: word_lookup = {1'b1, `OSC_IDX_DROOP};
         `OSC_CMD_FREQ: word_lookup = {1'b1, `OSC_IDX_FREQ};
         `OSC_CMD_PLACE: word_lookup = {1'b1, `OSC_IDX_PLACE};
         `OSC_CMD_GAIN: word_lookup = {1'b1, `OSC_IDX_GAIN};
         `OSC_CMD_IOFS: word_lookup = {1'b1, `OSC_IDX_IOFS};
         `OSC_CMD_OVT: word_lookup = {1'b1, `OSC_IDX_OVT};
         default: word_lookup = 5'h00;
      endcase
   endfunction
   // Linear word: signed 11-bit mantissa times two to a signed 5-bit exponent, fraction dropped
   function automatic logic signed [31:0] lin_value(input logic [15:0] w);
      logic signed [31:0] m;
      logic signed [5:0] x;
      m = 32'(signed'(w[`OSC_LIN_MANT_MSB:0]));
      x = 6'(signed'(w[`OSC_LIN_EXP_MSB:`OSC_LIN_EXP_LSB]));
      if (x >= 0)
         lin_value = m <<< x;
      else
         lin_value = m >>> (-x);
   endfunction
   // Millivolts to output-voltage counts for exponent e
   function automatic logic signed [31:0] mv_to_counts(input logic signed [31:0] mv, input logic signed [5:0] e);
      if (e >= 0)
         mv_to_counts = mv / (`OSC_MV_PER_V <<< e);
      else
         mv_to_counts = (mv <<< (-e)) / `OSC_MV_PER_V;
   endfunction
   function automatic logic signed [31:0] clamp_sym(input logic signed [31:0] v, input logic signed [31:0] lim);
      if (v > lim)
         clamp_sym = lim;
      else if (v < -lim)
         clamp_sym = -lim;
      else
         clamp_sym = v;
   endfunction

   // ****************************************
   // Word store and access port
   // ****************************************
   osc_word_t regs [NUM_WORDS];
   osc_word_t next_regs [NUM_WORDS];
   logic next_rsp_valid;
   logic next_rsp_nack;
   logic [15:0] next_rsp_rdata;
   logic [4:0] hit_idx;
   logic ceil_too_high;
   always_comb
   begin
      next_regs = regs;
      hit_idx = word_lookup(cmd_code);
      ceil_too_high = (32'(cmd_wdata) * `OSC_PCT_FULL) > (32'(setpoint_strap_pin) * `OSC_CEIL_PCT);
      next_rsp_valid = cmd_valid;
      next_rsp_nack = 1'b0;
      next_rsp_rdata = 16'h0000;
      if (cmd_valid)
      begin
         if (!hit_idx[4])
            next_rsp_nack = 1'b1;
         else if (cmd_write)
         begin
            if (hit_idx[3:0] == `OSC_IDX_CEIL && ceil_too_high)
               next_rsp_nack = 1'b1;
            else
               next_regs[hit_idx[3:0]] = cmd_wdata;
         end
         else
            next_rsp_rdata = regs[hit_idx[3:0]];
      end
   end
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         for (int i = 0; i < NUM_WORDS; i++)
            regs[i] <= `OSC_WORD_RST;
         regs[`OSC_IDX_CEIL] <= `OSC_CEIL_RST;
         rsp_valid <= 1'b0;
         rsp_nack <= 1'b0;
         rsp_rdata <= 16'h0000;
      end
      else if (ce)
      begin
         regs <= next_regs;
         rsp_valid <= next_rsp_valid;
         rsp_nack <= next_rsp_nack;
         rsp_rdata <= next_rsp_rdata;
      end
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   a_word_answer: assert property (ce && cmd_valid |=> rsp_valid) else $error("no answer to a word access");
   a_unmapped_nack: assert property (ce && cmd_valid && !hit_idx[4] |=> rsp_nack && rsp_rdata == 16'h0000)
      else $error("unmapped code not refused");
   a_write_read: assert property (ce && cmd_valid && cmd_write && hit_idx[4] && !(cmd_code == `OSC_CMD_CEIL
      && ceil_too_high) ##1 ce && !cmd_valid ##1 ce && cmd_valid && !cmd_write && cmd_code == $past(cmd_code, 2)
      |=> rsp_rdata == $past(cmd_wdata, 3)) else $error("read does not return last write");
   a_ceiling_refuse: assert property (ce && cmd_valid && cmd_write && cmd_code == `OSC_CMD_CEIL
      && ceil_too_high |=> rsp_nack && regs[`OSC_IDX_CEIL] == $past(regs[`OSC_IDX_CEIL]))
      else $error("ceiling above limit stored");

   // ****************************************
   // Setpoint composition
   // ****************************************
   logic signed [5:0] vexp;
   logic signed [31:0] trim_lim;
   logic signed [31:0] trim_c;
   logic signed [31:0] cal_c;
   logic signed [31:0] base;
   logic signed [31:0] sum;
   logic [15:0] next_target;
   always_comb
   begin
      if (vout_mode[`OSC_FMT_MSB:`OSC_FMT_LSB] == `OSC_FMT_LINEAR)
         vexp = 6'(signed'(vout_mode[`OSC_EXP_MSB:`OSC_EXP_LSB]));
      else
         vexp = 6'sd0;
      trim_lim = mv_to_counts(`OSC_TRIM_LIMIT_MV, vexp);
      trim_c = clamp_sym(32'(signed'(regs[`OSC_IDX_TRIM])), trim_lim);
      cal_c = clamp_sym(32'(signed'(regs[`OSC_IDX_CAL])), trim_lim);
      if (margin_sel == `OSC_MARGIN_HIGH)
         base = 32'(regs[`OSC_IDX_MHIGH]);
      else if (margin_sel == `OSC_MARGIN_LOW)
         base = 32'(regs[`OSC_IDX_MLOW]);
      else
         base = 32'(nominal_setpoint);
      sum = base + trim_c + cal_c;
      if (sum < 0)
         next_target = 16'h0000;
      else if (sum > 32'(regs[`OSC_IDX_CEIL]))
         next_target = regs[`OSC_IDX_CEIL];
      else
         next_target = sum[15:0];
   end
   a_trim_bound: assert property (trim_c <= trim_lim && trim_c >= -trim_lim
      && cal_c <= trim_lim && cal_c >= -trim_lim) else $error("applied trim exceeds limit");
   a_ceiling_clamp: assert property (ce |=> setpoint_target <= $past(regs[`OSC_IDX_CEIL]))
      else $error("setpoint above ceiling");
   a_margin_high: assert property (ce && margin_sel == `OSC_MARGIN_HIGH && trim_c == 0 && cal_c == 0
      && regs[`OSC_IDX_MHIGH] <= regs[`OSC_IDX_CEIL] |=> setpoint_target == $past(regs[`OSC_IDX_MHIGH]))
      else $error("margin high target not used");
   a_margin_low: assert property (ce && margin_sel == `OSC_MARGIN_LOW && trim_c == 0 && cal_c == 0
      && regs[`OSC_IDX_MLOW] <= regs[`OSC_IDX_CEIL] |=> setpoint_target == $past(regs[`OSC_IDX_MLOW]))
      else $error("margin low target not used");

   // ****************************************
   // Slew ramp and load line
   // ****************************************
   osc_ramp_t ramp_state;
   osc_ramp_t next_ramp_state;
   logic [31:0] tick_cnt;
   logic [31:0] next_tick_cnt;
   logic tick;
   logic signed [31:0] ramp_q;
   logic signed [31:0] next_ramp_q;
   logic signed [31:0] step;
   logic signed [6:0] shift;
   logic signed [31:0] droop;
   logic signed [31:0] drooped;
   logic [15:0] next_vout;
   always_comb
   begin
      tick = running && (tick_cnt == 32'(RAMP_TICK_CYCLES - 1));
      if (!running || tick)
         next_tick_cnt = 32'h0000_0000;
      else
         next_tick_cnt = tick_cnt + 32'h0000_0001;
      shift = 7'(signed'(regs[`OSC_IDX_SLEW][`OSC_LIN_EXP_MSB:`OSC_LIN_EXP_LSB])) - 7'(vexp);
      if (shift >= 0)
         step = 32'(signed'(regs[`OSC_IDX_SLEW][`OSC_LIN_MANT_MSB:0])) <<< shift;
      else
         step = 32'(signed'(regs[`OSC_IDX_SLEW][`OSC_LIN_MANT_MSB:0])) >>> (-shift);
      if (step < 1)
         step = 32'sd1;
      next_ramp_q = ramp_q;
      if (!running)
         next_ramp_q = 32'(setpoint_target);
      else if (tick)
      begin
         if (ramp_q < 32'(setpoint_target))
            next_ramp_q = (ramp_q + step > 32'(setpoint_target)) ? 32'(setpoint_target) : ramp_q + step;
         else if (ramp_q > 32'(setpoint_target))
            next_ramp_q = (ramp_q < 32'(setpoint_target) + step) ? 32'(setpoint_target) : ramp_q - step;
      end
      case (ramp_state)
         OSC_RAMP_IDLE,
         OSC_RAMP_UP,
         OSC_RAMP_DOWN:
            if (next_ramp_q < 32'(setpoint_target))
               next_ramp_state = OSC_RAMP_UP;
            else if (next_ramp_q > 32'(setpoint_target))
               next_ramp_state = OSC_RAMP_DOWN;
            else
               next_ramp_state = OSC_RAMP_IDLE;
         default:
            next_ramp_state = OSC_RAMP_IDLE;
      endcase
      droop = mv_to_counts(lin_value(regs[`OSC_IDX_DROOP]) * 32'(load_current), vexp);
      drooped = ramp_q - droop;
      if (drooped < 0)
         next_vout = 16'h0000;
      else
         next_vout = drooped[15:0];
   end
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         ramp_state <= OSC_RAMP_IDLE;
         tick_cnt <= 32'h0000_0000;
         ramp_q <= 32'sd0;
         setpoint_target <= 16'h0000;
         vout_setpoint <= 16'h0000;
         ramp_busy <= 1'b0;
      end
      else if (ce)
      begin
         ramp_state <= next_ramp_state;
         tick_cnt <= next_tick_cnt;
         ramp_q <= next_ramp_q;
         setpoint_target <= next_target;
         vout_setpoint <= next_vout;
         ramp_busy <= (next_ramp_state != OSC_RAMP_IDLE);
      end
   end
   a_ramp_hold: assert property (ce && running && !tick |=> ramp_q == $past(ramp_q))
      else $error("ramp moved between ticks");
   a_droop_zero: assert property (ce && regs[`OSC_IDX_DROOP] == 16'h0000 && ramp_q >= 0
      |=> vout_setpoint == $past(ramp_q[15:0])) else $error("output lowered without load line");

   // ****************************************
   // Frequency, phase_group_placement, current sense, overvoltage
   // ****************************************
   logic signed [31:0] freq_val;
   logic [4:0] next_rail_count;
   logic signed [31:0] gain_val;
   logic signed [31:0] iout_val;
   always_comb
   begin
      freq_val = lin_value(regs[`OSC_IDX_FREQ]);
      if (regs[`OSC_IDX_PLACE][`OSC_RAILS_MSB:`OSC_RAILS_LSB] == 4'h0)
         next_rail_count = `OSC_RAILS_ZERO_AS;
      else
         next_rail_count = {1'b0, regs[`OSC_IDX_PLACE][`OSC_RAILS_MSB:`OSC_RAILS_LSB]};
      gain_val = lin_value(regs[`OSC_IDX_GAIN]);
      if (gain_val > 0)
         iout_val = 32'(sense_mv) / gain_val;
      else
         iout_val = 32'sd0;
      iout_val = iout_val + lin_value(regs[`OSC_IDX_IOFS]);
   end
   always_ff @(posedge clk)
   begin
      if (reset)
      begin
         switch_khz <= 16'h0000;
         freq_in_range <= 1'b0;
         rail_count <= 5'h00;
         rail_position <= 4'h0;
         phase_deg <= 9'h000;
         iout_reading <= 16'h0000;
         ov_fault <= 1'b0;
      end
      else if (ce)
      begin
         switch_khz <= freq_val[15:0];
         freq_in_range <= (freq_val >= `OSC_FREQ_MIN_KHZ) && (freq_val <= `OSC_FREQ_MAX_KHZ);
         rail_count <= next_rail_count;
         rail_position <= regs[`OSC_IDX_PLACE][`OSC_POS_MSB:`OSC_POS_LSB];
         phase_deg <= 9'((32'(regs[`OSC_IDX_PLACE][`OSC_POS_MSB:`OSC_POS_LSB]) * `OSC_FULL_TURN_DEG)
            / 32'(next_rail_count));
         iout_reading <= iout_val[15:0];
         ov_fault <= (measured_vout > regs[`OSC_IDX_OVT]);
      end
   end
   a_rail_count: assert property (ce |=> rail_count == (($past(regs[`OSC_IDX_PLACE][7:4]) == 4'h0) ? 5'h10
      : {1'b0, $past(regs[`OSC_IDX_PLACE][7:4])})) else $error("rail count decode wrong");
   a_rail_position: assert property (ce |=> rail_position == $past(regs[`OSC_IDX_PLACE][3:0]))
      else $error("rail position decode wrong");
   a_phase_zero: assert property (ce && regs[`OSC_IDX_PLACE][3:0] == 4'h0 |=> phase_deg == 9'h000)
      else $error("first rail not at zero phase");
   a_ov_compare: assert property (ce |=> ov_fault == ($past(measured_vout) > $past(regs[`OSC_IDX_OVT])))
      else $error("overvoltage compare wrong");
endmodule

// >>> tb/osc_host_model.sv
// Bus host model issuing whole-word reads and writes to the setpoint bank
`timescale 1ns/10ps
module osc_host_model
(
   // Clock
   input wire logic clk,
   // Request side
   output logic cmd_valid,
   output logic cmd_write,
   output logic [7:0] cmd_code,
   output logic [15:0] cmd_wdata,
   // Answer side
   input wire logic rsp_valid,
   input wire logic rsp_nack,
   input wire logic [15:0] rsp_rdata
);
   initial
   begin
      cmd_valid = 1'b0;
      cmd_write = 1'b0;
      cmd_code = 8'h00;
      cmd_wdata = 16'h0000;
   end

   // One access; released lines show the inverse of the last value
   task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] wdata,
                         output logic nack, output logic [15:0] rdata);
      int n;
      n = 0;
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_write <= wr;
      cmd_code <= code;
      cmd_wdata <= wdata;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_write <= ~wr;
      cmd_code <= ~code;
      cmd_wdata <= ~wdata;
      #1;
      while (rsp_valid !== 1'b1 && n < 4)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      nack = (rsp_valid === 1'b1) ? rsp_nack : 1'bx;
      rdata = (rsp_valid === 1'b1) ? rsp_rdata : 16'hxxxx;
   endtask
endmodule

// >>> tb/osc_bank_tb_top.sv
// Self-checking bench for the output setpoint configuration bank
`timescale 1ns/10ps
`include "osc_defs.svh"
`define OSC_CHK(got, exp) \
   begin \
      n_compared++; \
      if ((got) !== (exp)) \
      begin \
         mismatches++; \
         $display("ERROR t=%0t got %h exp %h", $time, (got), (exp)); \
      end \
   end
module osc_bank_tb_top;
   // ****************************************
   // Signals
   // ****************************************
   logic clk = 1'b0;
   logic reset = 1'b1;
   logic ce = 1'b1;
   logic cmd_valid, cmd_write, rsp_valid, rsp_nack, ramp_busy, freq_in_range, ov_fault;
   logic [7:0] cmd_code;
   logic [15:0] cmd_wdata, rsp_rdata, setpoint_target, vout_setpoint, switch_khz, iout_reading;
   logic [15:0] nominal_setpoint = 16'h03e8;
   logic [1:0] margin_sel = 2'h0;
   logic running = 1'b0;
   logic [7:0] vout_mode = 8'h17;
   logic [15:0] setpoint_strap_pin = 16'h1000;
   logic [15:0] load_current = 16'h0000;
   logic [15:0] sense_mv = 16'h0064;
   logic [15:0] measured_vout = 16'h0000;
   logic [4:0] rail_count;
   logic [3:0] rail_position;
   logic [8:0] phase_deg;
   int mismatches = 0;
   int n_compared = 0;
   logic [7:0] codes [12] = '{8'h22, 8'h23, 8'h24, 8'h25, 8'h26, 8'h27, 8'h28, 8'h33, 8'h37, 8'h38, 8'h39, 8'h40};

   always #25 clk = ~clk;

   osc_bank #(.RAMP_TICK_CYCLES(8)) u_dut (.clk(clk), .reset(reset), .ce(ce), .cmd_valid(cmd_valid),
      .cmd_write(cmd_write), .cmd_code(cmd_code), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid),
      .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata), .nominal_setpoint(nominal_setpoint),
      .margin_sel(margin_sel), .running(running), .vout_mode(vout_mode),
      .setpoint_strap_pin(setpoint_strap_pin), .load_current(load_current), .sense_mv(sense_mv),
      .measured_vout(measured_vout), .setpoint_target(setpoint_target), .vout_setpoint(vout_setpoint),
      .ramp_busy(ramp_busy), .switch_khz(switch_khz), .freq_in_range(freq_in_range),
      .rail_count(rail_count), .rail_position(rail_position), .phase_deg(phase_deg),
      .iout_reading(iout_reading), .ov_fault(ov_fault));

   osc_host_model u_host (.clk(clk), .cmd_valid(cmd_valid), .cmd_write(cmd_write), .cmd_code(cmd_code),
      .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_nack(rsp_nack), .rsp_rdata(rsp_rdata));

   // ****************************************
   // Shared tasks
   // ****************************************
   task automatic wr(input logic [7:0] code, input logic [15:0] d, input logic exp_nack);
      logic nack;
      logic [15:0] rd;
      u_host.access(1'b1, code, d, nack, rd);
      `OSC_CHK(nack, exp_nack)
   endtask

   task automatic rd(input logic [7:0] code, input logic [15:0] exp, input logic exp_nack);
      logic nack;
      logic [15:0] d;
      u_host.access(1'b0, code, 16'h0000, nack, d);
      `OSC_CHK(nack, exp_nack)
      `OSC_CHK(d, exp)
   endtask

   task automatic settle();
      repeat (4) @(posedge clk);
      #1;
   endtask

   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, mismatches);
      if (mismatches == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_words();
      for (int i = 0; i < 12; i++)
         rd(codes[i], (i == 2) ? 16'hffff : 16'h0000, 1'b0);
      rd(8'h21, 16'h0000, 1'b1);
      wr(8'h29, 16'h1234, 1'b1);
      for (int i = 0; i < 12; i++)
         if (i != 2)
            wr(codes[i], {codes[i], ~codes[i]}, 1'b0);
      for (int i = 0; i < 12; i++)
         if (i != 2)
            rd(codes[i], {codes[i], ~codes[i]}, 1'b0);
      wr(`OSC_CMD_CEIL, 16'h1267, 1'b1);
      rd(`OSC_CMD_CEIL, 16'hffff, 1'b0);
      wr(`OSC_CMD_CEIL, 16'h1266, 1'b0);
      rd(`OSC_CMD_CEIL, 16'h1266, 1'b0);
   endtask

   task automatic t_setpoint();
      wr(`OSC_CMD_CAL, 16'h0000, 1'b0);
      wr(`OSC_CMD_TRIM, 16'h0014, 1'b0);
      settle();
      `OSC_CHK(setpoint_target, 16'h03fc)
      wr(`OSC_CMD_TRIM, 16'h00c8, 1'b0);
      settle();
      `OSC_CHK(setpoint_target, 16'h0434)
      wr(`OSC_CMD_CAL, 16'hfed4, 1'b0);
      settle();
      `OSC_CHK(setpoint_target, 16'h03e8)
      wr(`OSC_CMD_CAL, 16'h0000, 1'b0);
      wr(`OSC_CMD_TRIM, 16'h0014, 1'b0);
      @(posedge clk);
      vout_mode <= 8'h20;
      settle();
      `OSC_CHK(setpoint_target, 16'h03e8)
      @(posedge clk);
      vout_mode <= 8'h17;
      settle();
      `OSC_CHK(setpoint_target, 16'h03fc)
      wr(`OSC_CMD_TRIM, 16'h0000, 1'b0);
      wr(`OSC_CMD_CEIL, 16'h03f0, 1'b0);
      @(posedge clk);
      nominal_setpoint <= 16'h0400;
      settle();
      `OSC_CHK(setpoint_target, 16'h03f0)
      wr(`OSC_CMD_CEIL, 16'h1266, 1'b0);
      wr(`OSC_CMD_MHIGH, 16'h04b0, 1'b0);
      wr(`OSC_CMD_MLOW, 16'h0320, 1'b0);
      @(posedge clk);
      nominal_setpoint <= 16'h03e8;
      margin_sel <= `OSC_MARGIN_HIGH;
      settle();
      `OSC_CHK(setpoint_target, 16'h04b0)
      @(posedge clk);
      margin_sel <= `OSC_MARGIN_LOW;
      settle();
      `OSC_CHK(setpoint_target, 16'h0320)
      @(posedge clk);
      margin_sel <= 2'h0;
   endtask

   task automatic t_droop_ramp();
      int n;
      n = 0;
      wr(`OSC_CMD_DROOP, 16'h000a, 1'b0);
      @(posedge clk);
      load_current <= 16'h0064;
      settle();
      `OSC_CHK(vout_setpoint, 16'h01e8)
      wr(`OSC_CMD_SLEW, 16'he001, 1'b0);
      @(posedge clk);
      load_current <= 16'h0000;
      running <= 1'b1;
      settle();
      @(posedge clk);
      nominal_setpoint <= 16'h044c;
      repeat (3) @(posedge clk);
      #1;
      `OSC_CHK(ramp_busy, 1'b1)
      repeat (17) @(posedge clk);
      #1;
      `OSC_CHK(vout_setpoint == 16'h044c, 1'b0)
      while (ramp_busy !== 1'b0 && n < 40)
      begin
         @(posedge clk);
         #1;
         n++;
      end
      settle();
      `OSC_CHK(vout_setpoint, 16'h044c)
      @(posedge clk);
      running <= 1'b0;
   endtask

   task automatic t_fields();
      logic [15:0] fw [4] = '{16'h023a, 16'h023b, 16'h0320, 16'h0321};
      logic fr [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
      wr(`OSC_CMD_PLACE, 16'h0032, 1'b0);
      settle();
      `OSC_CHK(rail_count, 5'h03)
      `OSC_CHK(rail_position, 4'h2)
      `OSC_CHK(phase_deg, 9'h0f0)
      wr(`OSC_CMD_PLACE, 16'h0007, 1'b0);
      settle();
      `OSC_CHK(rail_count, 5'h10)
      `OSC_CHK(phase_deg, 9'h09d)
      for (int i = 0; i < 4; i++)
      begin
         wr(`OSC_CMD_FREQ, fw[i], 1'b0);
         settle();
         `OSC_CHK(switch_khz, fw[i])
         `OSC_CHK(freq_in_range, fr[i])
      end
      wr(`OSC_CMD_GAIN, 16'h0004, 1'b0);
      wr(`OSC_CMD_IOFS, 16'h0003, 1'b0);
      settle();
      `OSC_CHK(iout_reading, 16'h001c)
      wr(`OSC_CMD_GAIN, 16'h0000, 1'b0);
      settle();
      `OSC_CHK(iout_reading, 16'h0003)
      wr(`OSC_CMD_OVT, 16'h03e8, 1'b0);
      @(posedge clk);
      measured_vout <= 16'h03e8;
      settle();
      `OSC_CHK(ov_fault, 1'b0)
      @(posedge clk);
      measured_vout <= 16'h03e9;
      settle();
      `OSC_CHK(ov_fault, 1'b1)
      @(posedge clk);
      ce <= 1'b0;
      measured_vout <= 16'h0000;
      settle();
      `OSC_CHK(ov_fault, 1'b1)
      @(posedge clk);
      ce <= 1'b1;
      settle();
      `OSC_CHK(ov_fault, 1'b0)
   endtask

   // ****************************************
   // Sequence and watchdog
   // ****************************************
   initial
   begin
      repeat (3) @(posedge clk);
      reset <= 1'b0;
      @(posedge clk);
      t_words();
      t_setpoint();
      t_droop_ramp();
      t_fields();
      stop_test();
   end

   initial
   begin
      repeat (6000) @(posedge clk);
      mismatches++;
      stop_test();
   end
endmodule
